// ---- rtl/wdt_pkg.sv ----
/*
 * Shared constants and types for the windowed watchdog timer: register map,
 * field positions, reset values and prescaler ratios.
 * Assumes a 32-bit classic Wishbone slave with byte addresses on adr.
 */
package wdt_pkg;

	// Register byte offsets.
	localparam logic [7:0] OFF_CFG = 8'h00;
	localparam logic [7:0] OFF_RESET_CONTROL_REG = 8'h04;
	localparam logic [7:0] OFF_CMD = 8'h08;
	localparam logic [7:0] OFF_IST = 8'h0C;
	localparam logic [7:0] OFF_IMASK = 8'h10;
	localparam logic [7:0] OFF_COUNT = 8'h14;

	// Configuration word fields.
	localparam int CFG_ALWAYS_ON_BIT = 7;
	localparam int CFG_WIN_DIS_BIT = 6;
	localparam int CFG_PRE_BIT = 4;
	localparam int CFG_POST_LSB = 0;
	localparam int POST_W = 4;
	localparam logic [7:0] CFG_RESET = 8'hDF;
	localparam logic [7:0] CFG_WMASK = 8'hDF;

	// Reset control fields.
	localparam int RC_SWEN_BIT = 5;
	localparam int RC_TO_BIT = 4;
	localparam int RC_SLP_BIT = 3;
	localparam int RC_IDL_BIT = 2;

	// Command bits, interrupt status bits.
	localparam int CMD_CLR_BIT = 0;
	localparam int CMD_SLEEP_BIT = 1;
	localparam int CMD_IDLE_BIT = 2;
	localparam int IST_TO = 0;
	localparam int IST_WAKE = 1;
	localparam int IST_WIN = 2;
	localparam int IST_W = 3;

	// Low-power RC clock and scaler sizes.
	localparam int LOW_POWER_RC_CLOCK_FREQ_HZ = 32767;
	localparam int CNT_W = 22;
	localparam logic [CNT_W:0] PRE_DIV_SHORT = 23'h000020;
	localparam logic [CNT_W:0] PRE_DIV_LONG = 23'h000080;

	typedef enum logic [1:0] {PS_RUN, PS_SLEEP, PS_IDLE} power_state_t;

endpackage

// ---- rtl/wdt_scaler.sv ----
/*
 * Prescaler and postscaler of the watchdog merged into one tick counter.
 * Assumes tick_i is a one-cycle pulse per low-power RC clock period.
 */
`timescale 1ns/1ps
`default_nettype none
module wdt_scaler
	import wdt_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic clear_i,
	input wire logic tick_i,
	input wire logic pre_long_i,
	input wire logic [POST_W-1:0] post_sel_i,
	output logic expire_o,
	output logic late_o,
	output logic [CNT_W-1:0] count_o
);

	typedef struct packed {
		logic [CNT_W-1:0] cnt;
	} scaler_state_t;

	scaler_state_t s;
	scaler_state_t next_s;
	logic [CNT_W:0] span;
	logic [CNT_W:0] last;

	////////////////////////////////////////////////////////////////////////
	// One counter spans prescale times postscale, so the window quarter
	// is exact: every span is a power of two of at least 32 ticks.
	always_comb begin
		span = (pre_long_i ? PRE_DIV_LONG : PRE_DIV_SHORT) << post_sel_i;
		last = span - 23'h000001;
		expire_o = tick_i && ({1'b0, s.cnt} == last);
		late_o = {1'b0, s.cnt} >= (span - (span >> 2));
		count_o = s.cnt;
		next_s = s;
		if (clear_i) begin
			next_s.cnt = '0;
		end else if (tick_i) begin
			next_s.cnt = expire_o ? '0 : s.cnt + 22'h000001;
		end
	end

	// State register.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

endmodule
`default_nettype wire

// ---- rtl/windowed_watchdog_timer.sv ----
/*
 * Windowed watchdog timer with a classic Wishbone register slave.
 * Assumes the low-power RC clock arrives as a free-running pin, the CPU
 * issues clear and power-save commands through the command register, and
 * device_reset_o is fed back by the system into the CPU reset only.
 */
// The Wishbone interface to the registers and the address map were decided locally.
`timescale 1ns/1ps
`default_nettype none
module windowed_watchdog_timer
	import wdt_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	input wire logic low_power_rc_clock_clk_i,
	input wire logic clk_switch_done_i,
	output logic low_power_rc_clock_enable_o,
	output logic device_reset_o,
	output logic wake_o,
	output logic in_sleep_o,
	output logic in_idle_o,
	output logic irq_o
);

	typedef struct packed {
		logic [7:0] cfg;
		logic sw_en;
		logic to_flag;
		logic slp_flag;
		logic idl_flag;
		logic [IST_W-1:0] ist;
		logic [IST_W-1:0] imask;
		power_state_t ps;
		logic ack;
		logic [31:0] dat;
		logic irq;
		logic dev_rst;
		logic wake;
		logic low_power_rc_clock_en;
		logic asleep;
		logic idling;
		logic [2:0] sync;
	} wdt_state_t;

	wdt_state_t s;
	wdt_state_t next_s;

	logic tick;
	logic enabled;
	logic window_mode;
	logic req;
	logic wr;
	logic wr_cmd;
	logic clr_cmd;
	logic early_clear;
	logic timeout;
	logic scaler_clear;
	logic expire;
	logic late;
	logic [CNT_W-1:0] count;

	////////////////////////////////////////////////////////////////////////
	// The merged prescaler and postscaler.
	wdt_scaler i_wdt_scaler (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.clear_i(scaler_clear),
		.tick_i(tick),
		.pre_long_i(s.cfg[CFG_PRE_BIT]),
		.post_sel_i(s.cfg[CFG_POST_LSB +: POST_W]),
		.expire_o(expire),
		.late_o(late),
		.count_o(count)
	);

	////////////////////////////////////////////////////////////////////////
	// Decoded conditions of the current cycle.
	always_comb begin
		// The RC clock pin is sampled, never used as a clock, so the design
		// keeps one domain; the 50 MHz clock oversamples it by far.
		tick = s.sync[1] && !s.sync[2];
		enabled = s.cfg[CFG_ALWAYS_ON_BIT] || s.sw_en;
		window_mode = !s.cfg[CFG_WIN_DIS_BIT];
		req = wb_cyc_i && wb_stb_i;
		wr = req && s.ack && wb_we_i && wb_sel_i[0];
		wr_cmd = wr && (wb_adr_i[7:2] == OFF_CMD[7:2]);
		clr_cmd = wr_cmd && wb_dat_i[CMD_CLR_BIT] && (s.ps == PS_RUN);
		early_clear = clr_cmd && enabled && window_mode && !late;
		timeout = expire && enabled;
	end

	////////////////////////////////////////////////////////////////////////
	// Next-state logic: bus access first, then hardware events, so that a
	// hardware set always wins over a software clear in the same cycle.
	always_comb begin
		next_s = s;
		next_s.ack = 1'b0;
		next_s.dev_rst = 1'b0;
		next_s.wake = 1'b0;
		next_s.sync = {s.sync[1:0], low_power_rc_clock_clk_i};
		scaler_clear = !enabled || clk_switch_done_i;

		// Bus answer: ack one cycle after the request is seen, once.
		if (req && !s.ack) begin
			next_s.ack = 1'b1;
			unique case (wb_adr_i[7:2])
				OFF_CFG[7:2]: next_s.dat = {24'h000000, s.cfg};
				OFF_RESET_CONTROL_REG[7:2]: next_s.dat = {26'h0000000, s.sw_en, s.to_flag,
					s.slp_flag, s.idl_flag, 2'h0};
				OFF_IST[7:2]: next_s.dat = {29'h00000000, s.ist};
				OFF_IMASK[7:2]: next_s.dat = {29'h00000000, s.imask};
				OFF_COUNT[7:2]: next_s.dat = {10'h000, count};
				default: next_s.dat = 32'h00000000;
			endcase
		end

		// Register writes take effect on the edge that samples ack.
		if (wr) begin
			unique case (wb_adr_i[7:2])
				OFF_CFG[7:2]: next_s.cfg = wb_dat_i[7:0] & CFG_WMASK;
				OFF_RESET_CONTROL_REG[7:2]: begin
					next_s.sw_en = wb_dat_i[RC_SWEN_BIT];
					next_s.to_flag = s.to_flag && !wb_dat_i[RC_TO_BIT];
					next_s.slp_flag = s.slp_flag && !wb_dat_i[RC_SLP_BIT];
					next_s.idl_flag = s.idl_flag && !wb_dat_i[RC_IDL_BIT];
				end
				OFF_IST[7:2]: next_s.ist = s.ist & ~wb_dat_i[IST_W-1:0];
				OFF_IMASK[7:2]: next_s.imask = wb_dat_i[IST_W-1:0];
				default: begin
				end
			endcase
		end

		// Clear command: restarts the period; an early one also resets the device below.
		if (clr_cmd) begin
			scaler_clear = 1'b1;
		end

		// Power-save entry only from normal running.
		if (wr_cmd && (s.ps == PS_RUN) && !early_clear) begin
			if (wb_dat_i[CMD_SLEEP_BIT]) begin
				next_s.ps = PS_SLEEP;
				next_s.slp_flag = 1'b1;
				scaler_clear = 1'b1;
			end else if (wb_dat_i[CMD_IDLE_BIT]) begin
				next_s.ps = PS_IDLE;
				next_s.idl_flag = 1'b1;
				scaler_clear = 1'b1;
			end
		end

		// Timeout in Sleep or Idle wakes; flags stay for software.
		if (timeout && (s.ps != PS_RUN)) begin
			next_s.ps = PS_RUN;
			next_s.wake = 1'b1;
			next_s.to_flag = 1'b1;
			next_s.ist[IST_TO] = 1'b1;
			next_s.ist[IST_WAKE] = 1'b1;
			scaler_clear = 1'b1;
		end

		// Timeout while running, or an early clear, resets the device.
		if ((timeout && (s.ps == PS_RUN)) || early_clear) begin
			next_s.dev_rst = 1'b1;
			next_s.sw_en = 1'b0;
			next_s.ps = PS_RUN;
			scaler_clear = 1'b1;
			if (timeout) begin
				next_s.to_flag = 1'b1;
				next_s.ist[IST_TO] = 1'b1;
			end
			if (early_clear) begin
				next_s.ist[IST_WIN] = 1'b1;
			end
		end

		// Registered outputs derived from the next state.
		next_s.low_power_rc_clock_en = next_s.cfg[CFG_ALWAYS_ON_BIT] || next_s.sw_en;
		next_s.irq = |(next_s.ist & next_s.imask);
		// Power state levels are kept as flops so the pins carry no decode.
		next_s.asleep = (next_s.ps == PS_SLEEP);
		next_s.idling = (next_s.ps == PS_IDLE);
	end

	////////////////////////////////////////////////////////////////////////
	// State register; fuses come up unprogrammed, so the watchdog runs.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			s <= '0;
			s.cfg <= CFG_RESET;
			s.low_power_rc_clock_en <= 1'b1;
		end else begin
			s <= next_s;
		end
	end

	// Outputs straight from the state register.
	assign wb_dat_o = s.dat;
	assign wb_ack_o = s.ack;
	assign low_power_rc_clock_enable_o = s.low_power_rc_clock_en;
	assign device_reset_o = s.dev_rst;
	assign wake_o = s.wake;
	assign in_sleep_o = s.asleep;
	assign in_idle_o = s.idling;
	assign irq_o = s.irq;

	////////////////////////////////////////////////////////////////////////
	// Checks on the behaviour of the block.

	property p_always_on;
		@(posedge clk_i) disable iff (rst_i)
		(s.cfg[CFG_ALWAYS_ON_BIT] && !s.sw_en) |-> (low_power_rc_clock_enable_o && !scaler_clear)
			or clr_cmd or clk_switch_done_i or timeout or wr_cmd;
	endproperty
	a_always_on: assert property (p_always_on) else $error("always-on watchdog stopped");

	property p_sw_gate;
		@(posedge clk_i) disable iff (rst_i)
		(!s.cfg[CFG_ALWAYS_ON_BIT] && !s.sw_en) |-> (!low_power_rc_clock_enable_o && scaler_clear);
	endproperty
	a_sw_gate: assert property (p_sw_gate) else $error("disabled watchdog still runs");

	property p_reset_clears_en;
		@(posedge clk_i) disable iff (rst_i)
		device_reset_o |-> (!s.sw_en && count == '0);
	endproperty
	a_reset_clears_en: assert property (p_reset_clears_en) else $error("reset kept enable");

	property p_early_reset;
		@(posedge clk_i) disable iff (rst_i)
		early_clear |=> (device_reset_o && s.ist[IST_WIN]) ##1 !device_reset_o;
	endproperty
	a_early_reset: assert property (p_early_reset) else $error("early clear not punished");

	property p_late_clear_ok;
		@(posedge clk_i) disable iff (rst_i)
		(clr_cmd && late && !timeout) |=> (!device_reset_o && count == '0);
	endproperty
	a_late_clear_ok: assert property (p_late_clear_ok) else $error("late clear failed");

	property p_wake;
		@(posedge clk_i) disable iff (rst_i)
		(timeout && s.ps != PS_RUN) |=> (wake_o && !in_sleep_o && !in_idle_o && !device_reset_o);
	endproperty
	a_wake: assert property (p_wake) else $error("timeout did not wake");

	property p_flag_sticky;
		@(posedge clk_i) disable iff (rst_i)
		(s.to_flag && !(wr && wb_adr_i[7:2] == OFF_RESET_CONTROL_REG[7:2])) |=> s.to_flag;
	endproperty
	a_flag_sticky: assert property (p_flag_sticky) else $error("timeout flag lost");

	property p_run_timeout;
		@(posedge clk_i) disable iff (rst_i)
		(timeout && s.ps == PS_RUN) |=> (device_reset_o && s.to_flag && !wake_o);
	endproperty
	a_run_timeout: assert property (p_run_timeout) else $error("run timeout no reset");

	property p_sleep_entry;
		@(posedge clk_i) disable iff (rst_i)
		(wr_cmd && s.ps == PS_RUN && wb_dat_i[CMD_SLEEP_BIT] && !early_clear && !timeout)
			|=> (in_sleep_o && s.slp_flag && count == '0);
	endproperty
	a_sleep_entry: assert property (p_sleep_entry) else $error("sleep entry wrong");

	// A stopped watchdog must not creep towards a stale timeout.
	property p_disabled_hold;
		@(posedge clk_i) disable iff (rst_i)
		!enabled |=> (count == '0);
	endproperty
	a_disabled_hold: assert property (p_disabled_hold) else $error("disabled watchdog counted");

	property p_clock_switch;
		@(posedge clk_i) disable iff (rst_i)
		clk_switch_done_i |=> (count == '0);
	endproperty
	a_clock_switch: assert property (p_clock_switch) else $error("clock switch kept count");

	property p_plain_clear;
		@(posedge clk_i) disable iff (rst_i)
		(clr_cmd && !window_mode && !timeout) |=> !device_reset_o;
	endproperty
	a_plain_clear: assert property (p_plain_clear) else $error("plain mode clear reset");

	// Sleep and Idle must not freeze the count, only a timeout ends them.
	property p_sleep_counts;
		@(posedge clk_i) disable iff (rst_i)
		(s.ps != PS_RUN && enabled && tick && !expire && !clk_switch_done_i)
			|=> (count == $past(count) + 22'h000001);
	endproperty
	a_sleep_counts: assert property (p_sleep_counts) else $error("count froze in save");

	property p_save_state;
		@(posedge clk_i) disable iff (rst_i)
		(s.ps != PS_RUN && !timeout) |=> (s.ps == $past(s.ps));
	endproperty
	a_save_state: assert property (p_save_state) else $error("power state left early");

	property p_wake_pulse;
		@(posedge clk_i) disable iff (rst_i)
		wake_o |=> !wake_o;
	endproperty
	a_wake_pulse: assert property (p_wake_pulse) else $error("wake pulse too long");

	property p_reset_pulse;
		@(posedge clk_i) disable iff (rst_i)
		device_reset_o |=> !device_reset_o;
	endproperty
	a_reset_pulse: assert property (p_reset_pulse) else $error("reset pulse too long");

	property p_irq_level;
		@(posedge clk_i) disable iff (rst_i)
		irq_o == |(s.ist & s.imask);
	endproperty
	a_irq_level: assert property (p_irq_level) else $error("interrupt level wrong");

	property p_clock_enable;
		@(posedge clk_i) disable iff (rst_i)
		low_power_rc_clock_enable_o == (s.cfg[CFG_ALWAYS_ON_BIT] || s.sw_en);
	endproperty
	a_clock_enable: assert property (p_clock_enable) else $error("RC clock enable wrong");

endmodule
`default_nettype wire

// ---- verif/windowed_watchdog_timer_tb_top.sv ----
/*
 * Self-checking bench for the windowed watchdog timer: bus reads are scored
 * from a queue of expected values, event pulses are counted by a monitor.
 * Assumes the design package and a free-running RC clock of eight cycles.
 */
`timescale 1ns/1ps
`default_nettype none
module windowed_watchdog_timer_tb_top;
import wdt_pkg::*;
logic clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0, low_power_rc_clock = 0, sw_done = 0;
logic [3:0] sel = 4'h0;
logic [7:0] adr = 8'h00;
logic [31:0] dat = 32'h0, q, r, seed = 32'hA6C8;
logic [31:0] exp_q[$], msk_q[$];
logic [2:0] lp_div = 3'h0;
wire logic [31:0] dat_o;
wire logic ack, lp_en, dev_rst, wake, slp, idl, irq;
int mismatches = 0, total_checks = 0, cyc_n = 0, rst_cnt = 0, wake_cnt = 0, last_rst = 0;
int n, t0, b, c;
localparam int TK = 8;
windowed_watchdog_timer i_windowed_watchdog_timer(.clk_i(clk_i), .rst_i(rst_i),
	.wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
	.wb_dat_i(dat), .wb_dat_o(dat_o), .wb_ack_o(ack), .low_power_rc_clock_clk_i(low_power_rc_clock),
	.clk_switch_done_i(sw_done), .low_power_rc_clock_enable_o(lp_en), .device_reset_o(dev_rst),
	.wake_o(wake), .in_sleep_o(slp), .in_idle_o(idl), .irq_o(irq));
////////////////////////////////////////////////////////////////////////////////
// The system clock toggles each half period of 10 ns.
always #10 clk_i = ~clk_i;
// RC clock of eight system cycles keeps timeouts short yet above the synchroniser delay.
always @(posedge clk_i) begin
	lp_div <= lp_div + 3'h1;
	if (lp_div == 3'h3) begin
		low_power_rc_clock <= ~low_power_rc_clock;
		lp_div <= 3'h0;
	end
end
function automatic logic [31:0] xs();
	seed = seed ^ (seed << 13);
	seed = seed ^ (seed >> 17);
	seed = seed ^ (seed << 5);
	return seed;
endfunction
task chk(input logic [31:0] got, input logic [31:0] e);
	total_checks++;
	if (got !== e) begin
		mismatches++;
		$display("BAD t=%0t got %h expected %h", $time, got, e);
	end
endtask
// One classic cycle; random upper data bits are ignored by every register.
task wb(input logic [7:0] a, input logic w, input logic [7:0] d, input logic [31:0] e,
	input logic [31:0] m);
	r = xs();
	cyc <= 1'b1;
	stb <= 1'b1;
	we <= w;
	adr <= a;
	sel <= 4'hF;
	dat <= {r[23:0], d};
	if (!w) begin
		exp_q.push_back(e);
		msk_q.push_back(m);
	end
	n = 0;
	do begin
		@(posedge clk_i);
		n++;
	end while (ack !== 1'b1 && n < 100);
	// A slave that never answers counts as a mismatch.
	if (ack !== 1'b1) mismatches++;
	q = dat_o;
	cyc <= 1'b0;
	stb <= 1'b0;
	we <= 1'b0;
	@(posedge clk_i);
endtask
task wr(input logic [7:0] a, input logic [7:0] d);
	wb(a, 1'b1, d, 32'h0, 32'h0);
endtask
task rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
	wb(a, 1'b0, 8'h00, e, m);
endtask
// Waits, bounded, for the next reset pulse or wake pulse.
task wait_ev(input logic wk, input int lim);
	b = wk ? wake_cnt : rst_cnt;
	n = 0;
	while ((wk ? wake_cnt : rst_cnt) == b && n < lim) begin
		@(posedge clk_i);
		n++;
	end
	// An event that never comes counts as a mismatch.
	if ((wk ? wake_cnt : rst_cnt) == b) mismatches++;
	@(posedge clk_i);
endtask
task results();
	$display("checks %0d mismatches %0d", total_checks, mismatches);
	if (mismatches == 0 && total_checks > 0) $display("RESULT: PASS");
	else $display("RESULT: FAIL");
	$finish;
endtask
////////////////////////////////////////////////////////////////////////////////
// Monitor counts event pulses and scores read data against the oldest note.
always @(posedge clk_i) begin
	cyc_n++;
	if (dev_rst === 1'b1) begin
		rst_cnt++;
		last_rst = cyc_n;
	end
	if (wake === 1'b1) wake_cnt++;
	if (ack === 1'b1 && we === 1'b0 && exp_q.size() > 0) begin
		if (msk_q[0] != 32'h0) chk(dat_o & msk_q[0], exp_q[0]);
		void'(exp_q.pop_front());
		void'(msk_q.pop_front());
	end
end
// A hang ends the run through the same verdict.
initial begin
	repeat (20000) @(posedge clk_i);
	mismatches++;
	results();
end
initial begin
	repeat (6) @(posedge clk_i);
	rst_i <= 1'b0;
	@(posedge clk_i);
	rd(OFF_CFG, {24'h0, CFG_RESET}, 32'hFFFFFFFF);
	rd(OFF_RESET_CONTROL_REG, 32'h0, 32'h20);
	chk(lp_en, 32'h1);
	// Always-on fuse runs despite a clear enable bit; a run timeout resets.
	wr(OFF_RESET_CONTROL_REG, 8'h00);
	wr(OFF_CFG, 8'hC0);
	wait_ev(1'b0, 600);
	chk(rst_cnt, 32'h1);
	rd(OFF_RESET_CONTROL_REG, 32'h10, 32'h10);
	rd(OFF_IST, 32'h1, 32'h1);
	wr(OFF_IMASK, 8'h01);
	chk(irq, 32'h1);
	wr(OFF_IMASK, 8'h00);
	chk(irq, 32'h0);
	wr(OFF_IST, 8'h07);
	wr(OFF_IMASK, 8'h01);
	chk(irq, 32'h0);
	rd(OFF_RESET_CONTROL_REG, 32'h10, 32'h10);
	wr(OFF_RESET_CONTROL_REG, 8'h10);
	rd(OFF_RESET_CONTROL_REG, 32'h0, 32'h10);
	// Period per prescaler and postscaler code, tolerance covers synchroniser lag.
	for (int i = 0; i < 3; i++) begin
		c = (i == 0) ? 32 : (i == 1) ? 64 : 128;
		wr(OFF_CFG, (i == 0) ? 8'hC0 : (i == 1) ? 8'hC1 : 8'hD0);
		wr(OFF_CMD, 8'h01);
		t0 = cyc_n;
		wait_ev(1'b0, 1500);
		chk(32'(last_rst - t0 <= c * TK + 24 && last_rst - t0 >= c * TK - 24), 32'h1);
	end
	// Window mode: an early clear resets, a clear in the last quarter does not.
	wr(OFF_CFG, 8'h80);
	wait_ev(1'b0, 600);
	b = rst_cnt;
	wr(OFF_CMD, 8'h01);
	repeat (2) @(posedge clk_i);
	chk(rst_cnt, b + 1);
	rd(OFF_IST, 32'h4, 32'h4);
	repeat (210) @(posedge clk_i);
	b = rst_cnt;
	wr(OFF_CMD, 8'h01);
	repeat (4) @(posedge clk_i);
	chk(rst_cnt, b);
	// Software enable governs the watchdog when the fuse is clear.
	wr(OFF_CFG, 8'h40);
	repeat (2) @(posedge clk_i);
	chk(lp_en, 32'h0);
	b = rst_cnt;
	repeat (400) @(posedge clk_i);
	chk(rst_cnt, b);
	rd(OFF_COUNT, 32'h0, 32'hFFFFFFFF);
	wr(OFF_RESET_CONTROL_REG, 8'h20);
	chk(lp_en, 32'h1);
	wait_ev(1'b0, 600);
	chk(rst_cnt, b + 1);
	rd(OFF_RESET_CONTROL_REG, 32'h0, 32'h20);
	chk(lp_en, 32'h0);
	// Sleep then Idle: a timeout wakes instead of resetting, flags stay set.
	wr(OFF_CFG, 8'hC0);
	wr(OFF_RESET_CONTROL_REG, 8'h1C);
	for (int i = 0; i < 2; i++) begin
		c = rst_cnt;
		t0 = wake_cnt;
		wr(OFF_CMD, 8'(2 << i));
		chk(i ? idl : slp, 32'h1);
		wait_ev(1'b1, 600);
		chk(wake_cnt, t0 + 1);
		chk(rst_cnt, c);
		rd(OFF_RESET_CONTROL_REG, 32'h10 | (32'h8 >> i), 32'h1C);
		wr(OFF_RESET_CONTROL_REG, 8'h1C);
		rd(OFF_IST, 32'h2, 32'h2);
	end
	// A finished clock switch zeroes a count in progress.
	wr(OFF_CFG, 8'hC5);
	wr(OFF_CMD, 8'h01);
	repeat (100) @(posedge clk_i);
	sw_done <= 1'b1;
	@(posedge clk_i);
	sw_done <= 1'b0;
	rd(OFF_COUNT, 32'h0, 32'h0);
	chk(32'(q < 32'd3), 32'h1);
	rd(8'h1C, 32'h0, 32'hFFFFFFFF);
	results();
end
endmodule
`default_nettype wire
